/* File: inc/idmm_pkg.sv */
package idmm_pkg;
  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [7:0] IDMM_STACK_PTR_ADDR    = 8'h81;
  localparam logic [7:0] IDMM_STATUS_WORD_ADDR  = 8'hD0;
  localparam logic [7:0] IDMM_STACK_PTR_RESET   = 8'h07;
  localparam logic [7:0] IDMM_STATUS_WORD_RESET = 8'h00;
  localparam logic [7:0] IDMM_BIT_BASE          = 8'h20;
  localparam logic [7:0] IDMM_UPPER_START       = 8'h80;
  localparam int         IDMM_BANK_LO_POS       = 3;
  localparam int         IDMM_BANK_HI_POS       = 4;
  localparam int         IDMM_RAM_DEPTH         = 256;

  // ----------------------------------------
  // Operation codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    IDMM_OP_NONE     = 3'h0,
    IDMM_OP_DIRECT   = 3'h1,
    IDMM_OP_INDIRECT = 3'h2,
    IDMM_OP_REG      = 3'h3,
    IDMM_OP_BIT      = 3'h4,
    IDMM_OP_PUSH     = 3'h5,
    IDMM_OP_POP      = 3'h6
  } idmm_op_e;

  typedef enum logic [1:0] {
    IDMM_ST_IDLE = 2'b00,
    IDMM_ST_PTR  = 2'b01,
    IDMM_ST_ACC  = 2'b11
  } idmm_state_e;
endpackage : idmm_pkg

/* File: inc/idmm_ram_if.sv */
`timescale 1ns/1ns
interface idmm_ram_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface : idmm_ram_if

/* File: verif/idmm_sfs_model.sv */
`timescale 1ns/1ns
module idmm_sfs_model (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       sfs_valid,
  input  wire logic       sfs_write,
  input  wire logic [7:0] sfs_addr,
  input  wire logic [7:0] sfs_wdata,
  output logic [7:0]      sfs_rdata
);
  logic [7:0] regs [256];
  logic       pending;

  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i);
    end
  end

  // ----------------------------------------
  // Special space stand-in
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending <= 1'b0;
    end else begin
      pending <= sfs_valid;
      if (sfs_valid && sfs_write) begin
        regs[sfs_addr] <= sfs_wdata;
      end
    end
  end

  // Outside the answer window show the inverse, so a late sample is caught
  assign sfs_rdata = (sfs_valid || pending) ? regs[sfs_addr] : ~regs[sfs_addr];
endmodule : idmm_sfs_model

/* File: verif/internal_data_memory_map_tb.sv */
`timescale 1ns/1ns
module internal_data_memory_map_tb;
  localparam logic [2:0] DIR = idmm_pkg::IDMM_OP_DIRECT;
  localparam logic [2:0] IND = idmm_pkg::IDMM_OP_INDIRECT;
  localparam logic [2:0] REG = idmm_pkg::IDMM_OP_REG;
  localparam logic [2:0] BIT = idmm_pkg::IDMM_OP_BIT;
  localparam logic [2:0] PSH = idmm_pkg::IDMM_OP_PUSH;
  localparam logic [2:0] POP = idmm_pkg::IDMM_OP_POP;
  logic       core_clk  = 1'b0;
  logic       reset_n   = 1'b0;
  logic       req_valid = 1'b0;
  logic       req_write = 1'b0;
  logic [2:0] req_op    = 3'h0;
  logic [7:0] req_addr  = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic       req_ready, rsp_valid, sfs_valid, sfs_write;
  logic [7:0] rsp_rdata, sfs_addr, sfs_wdata, sfs_rdata, stack_top_pointer, program_status_word;
  logic [7:0] q;
  logic [7:0] byt [3] = '{8'h20, 8'h22, 8'h2F};
  logic [7:0] bta [3] = '{8'h00, 8'h13, 8'h7F};
  logic [7:0] msk [3] = '{8'h01, 8'h08, 8'h80};
  int         error_cnt = 0;
  int         checked   = 0;

  always #4 core_clk = ~core_clk;

  idmm_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_op(req_op), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .sfs_valid(sfs_valid), .sfs_write(sfs_write), .sfs_addr(sfs_addr),
    .sfs_wdata(sfs_wdata), .sfs_rdata(sfs_rdata), .stack_top_pointer(stack_top_pointer),
    .program_status_word(program_status_word));

  idmm_sfs_model sfs_u (.core_clk(core_clk), .reset_n(reset_n), .sfs_valid(sfs_valid),
    .sfs_write(sfs_write), .sfs_addr(sfs_addr), .sfs_wdata(sfs_wdata), .sfs_rdata(sfs_rdata));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic [2:0] op, input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    @(posedge core_clk) #1;
    req_valid = 1'b1;
    req_op    = op;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge core_clk) #1 n++;
    end
    @(posedge core_clk) #1 req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge core_clk) #1 n++;
    end
    chk({7'h00, rsp_valid}, 8'h01);
    q = rsp_rdata;
  endtask : xfer

  task automatic put(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d);
    xfer(op, 1'b1, a, d);
  endtask : put

  task automatic get(input logic [2:0] op, input logic [7:0] a, input logic [7:0] exp);
    xfer(op, 1'b0, a, 8'h00);
    chk(q, exp);
  endtask : get

  task automatic close_out;
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #16000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    #1 reset_n = 1'b1;
    chk(stack_top_pointer, 8'h07);
    get(DIR, 8'h81, 8'h07);
    xfer(3'h0, 1'b0, 8'h00, 8'h00);
    put(PSH, 8'h00, 8'h55);
    chk(stack_top_pointer, 8'h08);
    put(PSH, 8'h00, 8'h66);
    get(DIR, 8'h08, 8'h55);
    get(DIR, 8'h09, 8'h66);
    get(POP, 8'h00, 8'h66);
    get(POP, 8'h00, 8'h55);
    chk(stack_top_pointer, 8'h07);
    put(DIR, 8'h81, 8'hFE);
    put(PSH, 8'h00, 8'hAA);
    put(PSH, 8'h00, 8'hBB);
    chk(stack_top_pointer, 8'h00);
    get(DIR, 8'h00, 8'hBB);
    get(POP, 8'h00, 8'hBB);
    get(POP, 8'h00, 8'hAA);
    for (int b = 0; b < 4; b++) begin
      put(DIR, 8'hD0, 8'(b << 3));
      chk(program_status_word, 8'(b << 3));
      put(REG, 8'h07, 8'(8'hA0 + b));
      get(DIR, 8'(b * 8 + 7), 8'(8'hA0 + b));
      put(REG, 8'h01, 8'(8'h40 + b));
      put(IND, 8'h01, 8'(8'hC0 + b));
      get(DIR, 8'(8'h40 + b), 8'(8'hC0 + b));
    end
    put(DIR, 8'h90, 8'h3C);
    chk(sfs_addr, 8'h90);
    chk(sfs_wdata, 8'h3C);
    chk({7'h00, sfs_write}, 8'h01);
    put(REG, 8'h00, 8'h90);
    put(IND, 8'h00, 8'hC3);
    get(DIR, 8'h90, 8'h3C);
    get(IND, 8'h00, 8'hC3);
    for (int i = 0; i < 3; i++) begin
      put(DIR, byt[i], 8'h00);
      put(BIT, bta[i], 8'h01);
      get(DIR, byt[i], msk[i]);
      get(BIT, bta[i], 8'h01);
      put(DIR, byt[i], 8'hFF);
      put(BIT, bta[i], 8'h00);
      get(DIR, byt[i], ~msk[i]);
      get(BIT, bta[i], 8'h00);
    end
    // Second reset with pointer and bank moved away from their reset values
    @(posedge core_clk) #1 reset_n = 1'b0;
    @(posedge core_clk) #1 reset_n = 1'b1;
    chk(stack_top_pointer, 8'h07);
    chk(program_status_word, 8'h00);
    close_out();
  end
endmodule : internal_data_memory_map_tb

/* File: verilog/idmm_ram.sv */
`timescale 1ns/1ns
module idmm_ram (
  input wire logic core_clk,
  idmm_ram_if.mem  ram
);
  logic [7:0] store [idmm_pkg::IDMM_RAM_DEPTH];
  logic [7:0] rdata_q;

  // Storage kept free of reset so it maps onto a RAM macro
  always_ff @(posedge core_clk) begin
    if (ram.wr_en) begin
      store[ram.addr] <= ram.wdata;
    end
    rdata_q <= store[ram.addr];
  end
  assign ram.rdata = rdata_q;
endmodule : idmm_ram

/* File: verilog/idmm_top.sv */
`timescale 1ns/1ns
// How it works
// - A 256-byte internal RAM covers data addresses 0x00 through 0xFF.
// - Below 0x80 direct and indirect accesses reach the same RAM byte.
// - Addresses 0x00-0x1F form four banks of eight working registers.
// - The two bank-select bits at positions 3 and 4 of the status word pick one bank.
// - Bank values 0..3 map registers to 0x00, 0x08, 0x10 and 0x18 upward.
// - Indirect accesses take their address from register zero or one of the active bank.
// - Bytes 0x20-0x2F are also 128 single bits at bit addresses 0x00-0x7F.
// - Bit address n is bit n%8 of byte 0x20 plus n/8.
// - Bit or byte access is chosen only by the operation type.
// - The upper 128 RAM bytes are reached only by indirect accesses and the stack, and are apart from the special space.
// - Direct accesses above 0x7F go to the special-function space.
// - Indirect accesses above 0x7F go to the upper RAM.
// - A push writes at pointer plus one and then raises the pointer.
// - Reset loads the stack pointer with 0x07.
// - The stack pointer is read and written directly at 0x81.
// - The stack pointer wraps inside the 256-byte RAM.
module idmm_top (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       req_valid,
  input  wire logic [2:0] req_op,
  input  wire logic       req_write,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_wdata,
  output logic            req_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            sfs_valid,
  output logic            sfs_write,
  output logic [7:0]      sfs_addr,
  output logic [7:0]      sfs_wdata,
  input  wire logic [7:0] sfs_rdata,
  output logic [7:0]      stack_top_pointer,
  output logic [7:0]      program_status_word
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    idmm_pkg::idmm_state_e st;
    logic [2:0]            op;
    logic                  wr;
    logic [7:0]            addr;
    logic [7:0]            wdata;
    logic [2:0]            bitpos;
    logic [7:0]            stack_ptr;
    logic [7:0]            status_word;
    logic                  rsp_valid;
    logic [7:0]            rdata;
    logic                  sfs_valid;
    logic                  sfs_write;
    logic [7:0]            sfs_addr;
    logic [7:0]            sfs_wdata;
  } idmm_state_s;

  idmm_state_s cur;
  idmm_state_s next_cur;
  idmm_ram_if  ram ();

  idmm_ram u_ram (
    .core_clk (core_clk),
    .ram      (ram.mem)
  );

  logic [1:0] bank;
  logic [7:0] reg_base;
  logic [7:0] stack_ptr_inc;
  logic [7:0] dir_sfs_rd;
  assign bank          = {cur.status_word[idmm_pkg::IDMM_BANK_HI_POS],
                          cur.status_word[idmm_pkg::IDMM_BANK_LO_POS]};
  assign reg_base      = {3'h0, bank, 3'h0};
  assign stack_ptr_inc = 8'(cur.stack_ptr + 8'h01);

  // Pointer and status word answer locally, the rest goes outward
  always_comb begin
    unique case (cur.sfs_addr)
      idmm_pkg::IDMM_STACK_PTR_ADDR:   dir_sfs_rd = cur.stack_ptr;
      idmm_pkg::IDMM_STATUS_WORD_ADDR: dir_sfs_rd = cur.status_word;
      default:                         dir_sfs_rd = sfs_rdata;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_cur           = cur;
    next_cur.rsp_valid = 1'b0;
    next_cur.sfs_valid = 1'b0;
    ram.wr_en          = 1'b0;
    ram.addr           = 8'h00;
    ram.wdata          = cur.wdata;
    unique case (cur.st)
      idmm_pkg::IDMM_ST_IDLE: begin
        if (req_valid) begin
          next_cur.op     = req_op;
          next_cur.wr     = req_write;
          next_cur.wdata  = req_wdata;
          next_cur.bitpos = req_addr[2:0];
          next_cur.addr   = req_addr;
          unique case (idmm_pkg::idmm_op_e'(req_op))
            idmm_pkg::IDMM_OP_DIRECT: begin
              if (req_addr >= idmm_pkg::IDMM_UPPER_START) begin
                next_cur.sfs_addr  = req_addr;
                next_cur.sfs_wdata = req_wdata;
                next_cur.sfs_write = req_write;
                next_cur.sfs_valid = 1'b1;
                next_cur.st        = idmm_pkg::IDMM_ST_ACC;
              end else begin
                ram.addr    = req_addr;
                next_cur.st = idmm_pkg::IDMM_ST_ACC;
              end
            end
            idmm_pkg::IDMM_OP_INDIRECT: begin
              ram.addr    = reg_base | {7'h00, req_addr[0]};
              next_cur.st = idmm_pkg::IDMM_ST_PTR;
            end
            idmm_pkg::IDMM_OP_REG: begin
              ram.addr      = reg_base | {5'h00, req_addr[2:0]};
              next_cur.addr = reg_base | {5'h00, req_addr[2:0]};
              next_cur.st   = idmm_pkg::IDMM_ST_ACC;
            end
            idmm_pkg::IDMM_OP_BIT: begin
              // Bit address bit 7 is dropped, so operands above 0x7F alias onto bytes 0x20-0x2F here, never the special space
              next_cur.addr = idmm_pkg::IDMM_BIT_BASE + {4'h0, req_addr[6:3]};
              ram.addr      = idmm_pkg::IDMM_BIT_BASE + {4'h0, req_addr[6:3]};
              next_cur.st   = idmm_pkg::IDMM_ST_ACC;
            end
            idmm_pkg::IDMM_OP_PUSH: begin
              ram.wr_en          = 1'b1;
              ram.addr           = stack_ptr_inc;
              ram.wdata          = req_wdata;
              next_cur.stack_ptr = stack_ptr_inc;
              next_cur.rsp_valid = 1'b1;
            end
            idmm_pkg::IDMM_OP_POP: begin
              ram.addr           = cur.stack_ptr;
              next_cur.stack_ptr = cur.stack_ptr - 8'h01;
              next_cur.st        = idmm_pkg::IDMM_ST_ACC;
            end
            default: begin
              next_cur.rsp_valid = 1'b1;
            end
          endcase
        end
      end
      idmm_pkg::IDMM_ST_PTR: begin
        // Indirect target covers all 256 RAM bytes, never the special space
        ram.addr      = ram.rdata;
        next_cur.addr = ram.rdata;
        next_cur.st   = idmm_pkg::IDMM_ST_ACC;
      end
      idmm_pkg::IDMM_ST_ACC: begin
        next_cur.st        = idmm_pkg::IDMM_ST_IDLE;
        next_cur.rsp_valid = 1'b1;
        ram.addr           = cur.addr;
        if (cur.op == 3'(idmm_pkg::IDMM_OP_DIRECT) &&
            cur.addr >= idmm_pkg::IDMM_UPPER_START) begin
          next_cur.rdata = dir_sfs_rd;
          if (cur.wr && cur.addr == idmm_pkg::IDMM_STACK_PTR_ADDR) begin
            next_cur.stack_ptr = cur.wdata;
          end
          if (cur.wr && cur.addr == idmm_pkg::IDMM_STATUS_WORD_ADDR) begin
            next_cur.status_word = cur.wdata;
          end
        end else if (cur.op == 3'(idmm_pkg::IDMM_OP_BIT)) begin
          next_cur.rdata = {7'h00, ram.rdata[cur.bitpos]};
          if (cur.wr) begin
            ram.wr_en                 = 1'b1;
            ram.wdata                 = ram.rdata;
            ram.wdata[cur.bitpos]     = cur.wdata[0];
          end
        end else begin
          next_cur.rdata = ram.rdata;
          if (cur.wr && cur.op != 3'(idmm_pkg::IDMM_OP_POP)) begin
            ram.wr_en = 1'b1;
          end
        end
      end
      default: begin
        next_cur.st = idmm_pkg::IDMM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur     <= '0;
      cur.stack_ptr   <= idmm_pkg::IDMM_STACK_PTR_RESET;
      cur.status_word <= idmm_pkg::IDMM_STATUS_WORD_RESET;
      cur.st  <= idmm_pkg::IDMM_ST_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  assign req_ready           = (cur.st == idmm_pkg::IDMM_ST_IDLE);
  assign rsp_valid           = cur.rsp_valid;
  assign rsp_rdata           = cur.rdata;
  assign sfs_valid           = cur.sfs_valid;
  assign sfs_write           = cur.sfs_write;
  assign sfs_addr            = cur.sfs_addr;
  assign sfs_wdata           = cur.sfs_wdata;
  assign stack_top_pointer   = cur.stack_ptr;
  assign program_status_word = cur.status_word;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence push_taken;
    req_valid && req_ready && req_op == 3'(idmm_pkg::IDMM_OP_PUSH);
  endsequence
  sequence pop_taken;
    req_valid && req_ready && req_op == 3'(idmm_pkg::IDMM_OP_POP);
  endsequence

  AST_PUSH_INC: assert property (@(posedge core_clk) disable iff (!reset_n)
    push_taken |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("push did not raise pointer");
  AST_POP_DEC: assert property (@(posedge core_clk) disable iff (!reset_n)
    pop_taken |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01)
    else $error("pop did not lower pointer");
  AST_PUSH_ADDR: assert property (@(posedge core_clk) disable iff (!reset_n)
    push_taken |-> ram.wr_en && ram.addr == stack_top_pointer + 8'h01)
    else $error("push wrote wrong address");
  AST_BANK_BASE: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && req_op == 3'(idmm_pkg::IDMM_OP_REG)
    |-> ram.addr == {3'h0, program_status_word[4:3], req_addr[2:0]})
    else $error("working register address wrong");
  AST_DIR_SFS: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && req_op == 3'(idmm_pkg::IDMM_OP_DIRECT) && req_addr[7]
    |=> sfs_valid && sfs_addr == $past(req_addr))
    else $error("direct upper access not sent to special space");
  AST_IND_RAM: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && req_op == 3'(idmm_pkg::IDMM_OP_INDIRECT)
    |=> !sfs_valid ##1 !sfs_valid ##1 rsp_valid)
    else $error("indirect access timing or routing wrong");
  AST_IND_PTR: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && req_op == 3'(idmm_pkg::IDMM_OP_INDIRECT)
    |-> ram.addr == (reg_base | {7'h00, req_addr[0]}))
    else $error("index register address wrong");
  AST_BIT_ADDR: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && req_op == 3'(idmm_pkg::IDMM_OP_BIT)
    |-> ram.addr == 8'h20 + {4'h0, req_addr[6:3]})
    else $error("bit byte address wrong");
  AST_SP_RESET: assert property (@(posedge core_clk)
    $rose(reset_n) |-> stack_top_pointer == 8'h07)
    else $error("pointer not 0x07 after reset");
endmodule : idmm_top
